// >>> zone_host_model.sv
`timescale 1ns/10ps
// host side: downloads zone parameters and reads results over the word bus
module zone_host_model import zone_pkg::*; (
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	output logic [4:0] o_addr,
	output logic [15:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	// shortest period this host asks for while regulating
	localparam logic [15:0] PERIOD_FLOOR = 16'h0050;
	// idle bus at time zero
	initial begin
		o_addr = 5'h00;
		o_wdata = 16'h0000;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one-cycle write; data inverted after release so nothing leans on stale values
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask : wr
	// one-cycle read; data taken in the following cycle only
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rdata;
	endtask : rd
	// regulating period never below the floor, keeps duty resolution
	task automatic set_period(input logic [15:0] p);
		wr(A_PERIOD, (p < PERIOD_FLOOR) ? PERIOD_FLOOR : p);
	endtask : set_period
	// bias left at zero unless feedforward is wanted
	task automatic set_bias(input logic ff, input logic [15:0] b);
		wr(A_BIAS, ff ? b : 16'h0000);
	endtask : set_bias
endmodule : zone_host_model

// >>> zone_pid_pwm_temperature_loop.sv
`timescale 1ns/10ps
// Overview of operation
// - zero P or D gain removes that action; zero I gain holds the integral
// - setpoint up to sensor full scale
// - deviation and alarm bands up to full scale
// - deviation excursion captures temperature, flags error
// - alarm excursion flags; upper alarm cuts output
// - pulse period 0.1 s to 60 s
// - on pulses are whole 8 ms units, except full on for the whole period
// - leftover on-time carried into next pulse
// - true temperature is reading plus compensation
// - internal sensor compensates direct terminal wiring
// - regulate only in use, enabled, auto, sensor ok
// - compute once per period from four samples
// - output is P, I, bias minus D
// - clamp to zero or full, else scale
// - outside linear zone integral is frozen
// - below zone full on, above zone off
// - inside zone error limited to host limit
// - config bits 1:0 select sensor type
// - config bits pick compensation source
// - out of range downloads dropped, error reported
module zone_pid_pwm_temperature_loop import zone_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic I_CLK,
	input wire logic I_RST_B,
	input wire logic [4:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic [15:0] I_TC_REL,
	input wire logic [15:0] I_INT_CJ,
	input wire logic [15:0] I_RTD_CJ,
	input wire logic I_TC_ERR,
	output logic O_HEAT,
	output logic O_CTRL_ERR
);
	zone_param_s par_r;
	zone_param_s par_nxt;
	logic [1:0] ctl_r;
	logic dev_flag_r;
	logic alm_flag_r;
	logic [15:0] captured_r;
	logic [7:0] errcode_r;
	logic signed [47:0] integ_r;
	logic signed [15:0] x1_r;
	logic signed [15:0] x2_r;
	logic signed [15:0] x3_r;
	logic [15:0] act_r;
	logic [15:0] rdata_r;
	logic heat_r;
	logic [15:0] rd_val;
	logic pwm_heat;
	logic sample;

	// sensor full scale by type; the unused code runs at the K scale
	function automatic logic [15:0] full_scale(input logic [1:0] t);
		return (t == TYPE_J || t == TYPE_L) ? FULL_JL : FULL_K;
	endfunction : full_scale

	// download range check per parameter
	function automatic logic param_ok(input logic [4:0] a, input logic [15:0] d,
		input logic [15:0] fs);
		logic ok;
		ok = 1'b1;
		case (a)
			A_SETPOINT: ok = (d <= fs);
			A_MANUAL: ok = (d <= LIM_MANUAL);
			A_ERR_LIMIT, A_LIN_ZONE: ok = (d != 16'h0000) && (d <= LIM_TEMP);
			A_EXT_COMP: ok = (d <= LIM_TEMP);
			A_BIAS: ok = ($signed(d) >= -LIM_BIAS) && ($signed(d) <= LIM_BIAS);
			A_KP, A_KI, A_KD: ok = (d <= LIM_GAIN);
			A_PERIOD: ok = (d >= LIM_PER_LO) && (d <= LIM_PER_HI);
			A_UP_DEV, A_LO_DEV, A_LO_ALARM: ok = (d <= fs);
			A_UP_ALARM: ok = (d >= LIM_UP_ALARM_LO) && (d <= fs);
			A_CONFIG: ok = (d <= LIM_CONFIG);
			default: ok = 1'b1;
		endcase
		return ok;
	endfunction : param_ok

	////////////////////////////////////////////////////////////////
	// register bus decode
	wire [15:0] cfg = par_r.cfg_word;
	wire [15:0] fs = full_scale(cfg[CFG_TYPE_HI:0]);
	wire wr_param = I_WR && (I_ADDR <= A_CONFIG);
	wire wr_ok = wr_param && param_ok(I_ADDR, I_WDATA, fs);
	wire wr_bad = wr_param && !wr_ok;
	wire wr_ctl = I_WR && (I_ADDR == A_CONTROL);
	wire clr_dev = I_WR && (I_ADDR == A_STATUS) && I_WDATA[ST_DEV];
	wire clr_alm = I_WR && (I_ADDR == A_STATUS) && I_WDATA[ST_ALARM];
	wire clr_err = I_WR && (I_ADDR == A_ERRCODE);

	// accepted downloads replace one field, refused ones leave all intact
	always_comb begin
		par_nxt = par_r;
		if (wr_ok) begin
			case (I_ADDR)
				A_SETPOINT: par_nxt.setpoint = I_WDATA;
				A_MANUAL: par_nxt.manual = I_WDATA;
				A_ERR_LIMIT: par_nxt.err_limit = I_WDATA;
				A_LIN_ZONE: par_nxt.lin_zone = I_WDATA;
				A_EXT_COMP: par_nxt.ext_comp = I_WDATA;
				A_BIAS: par_nxt.bias = I_WDATA;
				A_KP: par_nxt.proportional_gain = I_WDATA;
				A_KI: par_nxt.integral_gain = I_WDATA;
				A_KD: par_nxt.derivative_gain = I_WDATA;
				A_PERIOD: par_nxt.pulse_period = I_WDATA;
				A_UP_DEV: par_nxt.up_dev = I_WDATA;
				A_LO_DEV: par_nxt.lo_dev = I_WDATA;
				A_UP_ALARM: par_nxt.up_alarm = I_WDATA;
				A_LO_ALARM: par_nxt.lo_alarm = I_WDATA;
				A_CONFIG: par_nxt.cfg_word = I_WDATA;
				default: par_nxt = par_r;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// compensated temperature and bands, all in 0.1 degree
	wire [15:0] comp = cfg[CFG_HOST_COMP] ? par_r.ext_comp :
		(cfg[CFG_EXT_RTD] ? I_RTD_CJ : I_INT_CJ);
	wire signed [15:0] temp = $signed(I_TC_REL + comp);
	wire signed [17:0] t18 = {{2{temp[15]}}, temp};
	wire signed [17:0] sp18 = $signed({2'b00, par_r.setpoint});
	wire signed [17:0] lim18 = $signed({2'b00, par_r.err_limit});
	wire signed [17:0] zone18 = $signed({2'b00, par_r.lin_zone});
	wire signed [17:0] err_raw = sp18 - t18;
	wire signed [17:0] err_clip = (err_raw > lim18) ? lim18 :
		((err_raw < -lim18) ? -lim18 : err_raw);
	wire below_zone = t18 < sp18 - zone18;
	wire above_zone = t18 > sp18 + zone18;
	wire in_zone = !below_zone && !above_zone;
	wire in_use = cfg[CFG_IN_USE];
	wire out_en = ctl_r[CTL_OUT_EN];
	wire active = in_use && out_en && ctl_r[CTL_AUTO] && !I_TC_ERR;
	wire dev_ev = in_use && ((t18 > sp18 + $signed({2'b00, par_r.up_dev})) ||
		(t18 < sp18 - $signed({2'b00, par_r.lo_dev})));
	wire alm_hi = in_use && (t18 > sp18 + $signed({2'b00, par_r.up_alarm}));
	wire alm_ev = alm_hi || (in_use && (t18 < sp18 - $signed({2'b00, par_r.lo_alarm})));

	////////////////////////////////////////////////////////////////
	// modified PID, evaluated at the period boundary
	wire signed [47:0] e48 = {{30{err_clip[17]}}, err_clip};
	wire signed [47:0] kp48 = $signed({32'h0000_0000, par_r.proportional_gain});
	wire signed [47:0] ki48 = $signed({32'h0000_0000, par_r.integral_gain});
	wire signed [47:0] kd48 = $signed({32'h0000_0000, par_r.derivative_gain});
	wire signed [47:0] per48 = $signed({32'h0000_0000, par_r.pulse_period});
	wire signed [47:0] fs48 = $signed({32'h0000_0000, fs});
	wire signed [47:0] bias48 = {{32{par_r.bias[15]}}, par_r.bias};
	wire signed [47:0] x0_48 = {{32{temp[15]}}, temp};
	wire signed [47:0] x1_48 = {{32{x1_r[15]}}, x1_r};
	wire signed [47:0] x2_48 = {{32{x2_r[15]}}, x2_r};
	wire signed [47:0] x3_48 = {{32{x3_r[15]}}, x3_r};
	wire signed [47:0] dx = x0_48 - x3_48 + 48'sd3 * (x1_48 - x2_48);
	wire integ_run = active && in_zone && (par_r.integral_gain != 16'h0000);
	wire signed [47:0] integ_nxt = integ_run ? integ_r + ki48 * per48 * e48 : integ_r;
	wire signed [47:0] p_term = (par_r.proportional_gain != 16'h0000) ?
		kp48 * e48 / 48'(KP_DIV) : 48'sd0;
	wire signed [47:0] i_term = integ_nxt / 48'(KI_DIV);
	wire signed [47:0] d_term = (par_r.derivative_gain != 16'h0000) ?
		kd48 * 48'(KD_MUL) * dx / (48'(KD_DIV) * per48) : 48'sd0;
	wire signed [47:0] b_term = bias48 * fs48 / 48'(DUTY_DIV);
	wire signed [47:0] y = p_term + i_term - d_term + b_term;

	// actuating value to on-time in ms
	wire [15:0] per_ms = 16'(par_r.pulse_period * 16'(PERIOD_UNIT_MS));
	wire signed [47:0] per_ms48 = $signed({32'h0000_0000, per_ms});
	wire signed [47:0] lin_ms = y * per_ms48 / fs48;
	wire [15:0] auto_ms = below_zone ? per_ms : (above_zone ? 16'h0000 :
		((y < 48'sd0) ? 16'h0000 : ((y > fs48) ? per_ms : lin_ms[15:0])));
	wire [15:0] man_ms = 16'(({16'h0000, par_r.manual} * {16'h0000, per_ms}) / 32'(DUTY_DIV));
	wire man_run = in_use && out_en && !ctl_r[CTL_AUTO] && !I_TC_ERR;
	wire [15:0] on_ms = alm_hi ? 16'h0000 : (active ? auto_ms : (man_run ? man_ms : 16'h0000));

	// pulse generator; its boundary pulse is the sampling instant
	zone_pulse_gen #(.MS_CYCLES(MS_CYCLES)) u_pulse (
		.i_clk(I_CLK),
		.i_rst_b(I_RST_B),
		.i_period_ms(per_ms),
		.i_on_ms(on_ms),
		.o_heat(pwm_heat),
		.o_sample(sample)
	);

	////////////////////////////////////////////////////////////////
	// parameters, control and history
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			par_r <= '{err_limit: RST_ONE, lin_zone: RST_ONE, up_alarm: LIM_UP_ALARM_LO,
				pulse_period: RST_PERIOD, default: 16'h0000};
			ctl_r <= 2'h0;
		end else begin
			par_r <= par_nxt;
			ctl_r <= wr_ctl ? I_WDATA[1:0] : ctl_r;
		end
	end

	// history shifts once per period so the derivative sees four samples
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			x1_r <= 16'sh0000;
			x2_r <= 16'sh0000;
			x3_r <= 16'sh0000;
			integ_r <= 48'sh0;
			act_r <= 16'h0000;
		end else if (sample) begin
			x1_r <= temp;
			x2_r <= x1_r;
			x3_r <= x2_r;
			integ_r <= integ_nxt;
			act_r <= active ? y[15:0] : 16'h0000;
		end
	end

	// sticky flags; a fresh event beats a clear in the same cycle
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			dev_flag_r <= 1'b0;
			alm_flag_r <= 1'b0;
			captured_r <= 16'h0000;
			errcode_r <= 8'h00;
		end else begin
			dev_flag_r <= dev_ev || (dev_flag_r && !clr_dev);
			alm_flag_r <= alm_ev || (alm_flag_r && !clr_alm);
			if ((dev_ev && !dev_flag_r) || (alm_ev && !alm_flag_r)) begin
				captured_r <= temp;
			end
			if (wr_bad) begin
				errcode_r <= {CHANNEL_NUM, I_ADDR[3:0] + 4'h1};
			end else if (clr_err) begin
				errcode_r <= 8'h00;
			end
		end
	end

	// output stage; upper alarm, sensor loss or idle cut at once, not at period end
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			heat_r <= 1'b0;
		end else begin
			heat_r <= pwm_heat && out_en && in_use && !alm_hi && !I_TC_ERR;
		end
	end
	assign O_HEAT = heat_r;
	assign O_CTRL_ERR = dev_flag_r || alm_flag_r;

	////////////////////////////////////////////////////////////////
	// read back; data stand only in the cycle after the strobe
	always_comb begin
		case (I_ADDR)
			A_CONTROL: rd_val = {14'h0000, ctl_r};
			A_STATUS: rd_val = {12'h000, active, alm_hi, alm_flag_r, dev_flag_r};
			A_CAPTURED: rd_val = captured_r;
			A_MEASURED: rd_val = temp;
			A_ERRCODE: rd_val = {8'h00, errcode_r};
			A_ACTUATE: rd_val = act_r;
			default: rd_val = (I_ADDR <= A_CONFIG) ? par_r[16 * (14 - I_ADDR) +: 16] : 16'h0000;
		endcase
	end

	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rdata_r <= 16'h0000;
		end else begin
			rdata_r <= I_RD ? rd_val : 16'h0000;
		end
	end
	assign O_RDATA = rdata_r;

	////////////////////////////////////////////////////////////////
	// checks
	a_bad_param_kept: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		wr_bad |=> (par_r == $past(par_r)) && (errcode_r[3:0] == $past(I_ADDR[3:0]) + 4'h1))
		else $error("refused download changed state");
	a_alarm_cuts_heat: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		alm_hi |=> !O_HEAT)
		else $error("heater on above upper alarm");
	a_dev_flag_sets: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		dev_ev |=> dev_flag_r && O_CTRL_ERR)
		else $error("deviation not flagged");
	a_integral_frozen: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(sample && !in_zone) |=> (integ_r == $past(integ_r)))
		else $error("integral moved outside zone");
	a_below_zone_full: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(active && below_zone && !alm_hi) |-> (on_ms == per_ms))
		else $error("not full on below zone");
	a_above_zone_off: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(active && above_zone) |-> (on_ms == 16'h0000))
		else $error("not off above zone");
	a_negative_clamp: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(active && in_zone && (y < 48'sd0)) |-> (on_ms == 16'h0000))
		else $error("negative value not clamped");
	a_idle_no_heat: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(!in_use || !out_en) |=> !O_HEAT)
		else $error("heater on while zone idle");
	a_sensor_err_off: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		I_TC_ERR |=> !O_HEAT)
		else $error("heater on during sensor error");
	a_error_clipped: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
		(err_clip <= lim18) && (err_clip >= -lim18))
		else $error("error exceeds limit");
endmodule : zone_pid_pwm_temperature_loop

// >>> zone_pid_pwm_temperature_loop_tb.sv
`timescale 1ns/10ps
module zone_pid_pwm_temperature_loop_tb import zone_pkg::*; ;
	localparam int MS = 1;
	localparam int PC = 80 * PERIOD_UNIT_MS * MS; // cycles in one 800 ms period
	logic clk, rst_b, wr, rd, tc_err, heat, ctrl_err;
	logic [4:0] addr;
	logic [15:0] wdata, rdata, tc_rel, int_cj, rtd_cj, rv, cj_host;
	logic [15:0] shadow [0:15];
	int pick [12] = '{0, 1, 2, 3, 4, 6, 7, 8, 10, 11, 12, 13};
	int error_cnt = 0;
	int check_count = 0;
	int hi, v, fs;
	logic [4:0] adr;
	// free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	zone_pid_pwm_temperature_loop #(.MS_CYCLES(MS)) u_dut (.I_CLK(clk), .I_RST_B(rst_b),
		.I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.I_TC_REL(tc_rel), .I_INT_CJ(int_cj), .I_RTD_CJ(rtd_cj), .I_TC_ERR(tc_err),
		.O_HEAT(heat), .O_CTRL_ERR(ctrl_err));
	zone_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	////////////////////////////////////////////////////////////////////////////////
	// comparison, reporting and stimulus helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_near(input int got, input int exp, input int tol);
		check_count++;
		if (got < exp - tol || got > exp + tol) begin
			error_cnt++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_near
	task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
		u_host.rd(a, rv);
		chk(rv, exp);
	endtask : rchk
	task automatic summarize;
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : summarize
	task automatic do_reset;
		rst_b <= 1'b0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	endtask : do_reset
	// true temperature t, reading offset by the internal compensation
	task automatic temp(input int t);
		@(posedge clk);
		tc_rel <= 16'(t) - int_cj;
	endtask : temp
	// heater high count; runs that start inside the window must be whole 8 ms units
	task automatic heat_count(input int cyc, input bit runs, output int n);
		int run;
		bit lo_seen;
		n = 0;
		run = 0;
		lo_seen = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			if ($isunknown(heat)) chk({15'h0000, heat}, 16'h0000);
			if (heat === 1'b1) begin
				n++;
				run += lo_seen;
			end else begin
				if (runs && run != 0) chk_near(run % (QUANT_MS * MS), 0, 0);
				run = 0;
				lo_seen = 1;
			end
		end
	endtask : heat_count
	function automatic int hi_lim(input logic [4:0] a);
		case (a)
			A_MANUAL: return 1000;
			A_ERR_LIMIT, A_LIN_ZONE, A_EXT_COMP: return 6500;
			A_KP, A_KI, A_KD: return 32000;
			default: return 6000; // temperatures against type K full scale
		endcase
	endfunction : hi_lim
	// watchdog: a hang ends the run as a mismatch
	initial begin
		#800_000;
		error_cnt++;
		summarize();
	end
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		rst_b = 1'b0;
		tc_rel = 16'h0000;
		int_cj = 16'h0000;
		rtd_cj = 16'h0000;
		tc_err = 1'b0;
		void'($urandom(19922));
		do_reset();
		rchk(A_PERIOD, RST_PERIOD);
		rchk(5'h1F, 16'h0000);
		for (int k = 0; k < 16; k++) shadow[k] = (k == 2 || k == 3) ? RST_ONE : 16'h0000;
		shadow[12] = LIM_UP_ALARM_LO;
		// random downloads, a quarter of them beyond the upper limit
		repeat (40) begin
			adr = 5'(pick[$urandom_range(0, 11)]);
			v = $urandom_range(0, 3) == 0 ? hi_lim(adr) + 1 + $urandom_range(0, 30)
				: $urandom_range((adr == A_UP_ALARM) ? 200 : 1, hi_lim(adr));
			u_host.wr(adr, 16'(v));
			if (v <= hi_lim(adr)) shadow[adr] = 16'(v);
			rchk(adr, shadow[adr]);
			rchk(A_ERRCODE, v > hi_lim(adr) ? {8'h00, 4'h1, 4'(adr + 5'h01)} : 16'h0000);
			u_host.wr(A_ERRCODE, 16'h0000);
		end
		u_host.wr(A_PERIOD, 16'h0009);
		rchk(A_ERRCODE, 16'h001A);
		u_host.wr(A_PERIOD, 16'h1771);
		rchk(A_PERIOD, RST_PERIOD);
		u_host.wr(A_PERIOD, 16'h1770);
		rchk(A_PERIOD, 16'h1770);
		u_host.wr(A_BIAS, 16'hFC17);
		rchk(A_ERRCODE, 16'h0016);
		do_reset();
		// full scale follows the sensor type: J, L, then K
		for (int t = 0; t < 3; t++) begin
			fs = (t == 2) ? 6000 : 4500;
			u_host.wr(A_CONFIG, (t == 2) ? 16'h0000 : 16'(t + 1));
			u_host.wr(A_SETPOINT, 16'(fs + 1));
			rchk(A_ERRCODE, 16'h0011);
			u_host.wr(A_SETPOINT, 16'(fs));
			rchk(A_SETPOINT, 16'(fs));
			u_host.wr(A_UP_DEV, 16'(fs + 1));
			rchk(A_ERRCODE, 16'h001B);
		end
		// compensation source: internal, resistive detector, host value
		u_host.set_period(16'h0050);
		cj_host = 16'($urandom_range(501, 700));
		u_host.wr(A_EXT_COMP, cj_host);
		@(posedge clk);
		tc_rel <= 16'($urandom_range(0, 1500));
		int_cj <= 16'($urandom_range(100, 300));
		rtd_cj <= 16'($urandom_range(301, 500));
		for (int s = 0; s < 3; s++) begin
			u_host.wr(A_CONFIG, 16'h0080 | (s == 1 ? 16'h0008 : s == 2 ? 16'h0040 : 16'h0000));
			repeat (PC + 40) @(posedge clk);
			rchk(A_MEASURED, tc_rel + (s == 0 ? int_cj : s == 1 ? rtd_cj : cj_host));
		end
		u_host.wr(A_CONFIG, 16'h0080);
		u_host.wr(A_SETPOINT, 16'h03E8);
		u_host.wr(A_UP_DEV, 16'h01F4);
		u_host.wr(A_LO_DEV, 16'h01F4);
		u_host.wr(A_UP_ALARM, 16'h03E8);
		u_host.wr(A_LO_ALARM, 16'h03E8);
		temp(1000);
		// manual 50.3 percent: quantised pulses averaging the exact duty
		u_host.wr(A_MANUAL, 16'h01F7);
		u_host.wr(A_CONTROL, 16'h0001);
		repeat (2 * PC) @(posedge clk);
		heat_count(5 * PC, 1'b1, hi);
		chk_near(hi, 5 * PC * 503 / 1000, PC / 2);
		@(posedge clk);
		tc_err <= 1'b1;
		heat_count(PC, 1'b0, hi);
		chk_near(hi, 0, 4);
		// automatic mode outside the linear zone, integral primed but frozen
		@(posedge clk);
		tc_err <= 1'b0;
		u_host.wr(A_LIN_ZONE, 16'h0064);
		u_host.wr(A_ERR_LIMIT, 16'h0064);
		u_host.wr(A_KP, 16'h03E8);
		u_host.wr(A_KI, 16'h03E8);
		u_host.wr(A_CONTROL, 16'h0003);
		temp(700);
		repeat (2 * PC) @(posedge clk);
		u_host.rd(A_STATUS, rv);
		chk({15'h0000, rv[ST_ACTIVE]}, 16'h0001);
		heat_count(2 * PC, 1'b0, hi);
		chk_near(hi, 2 * PC, 0);
		temp(1150);
		repeat (2 * PC) @(posedge clk);
		heat_count(2 * PC, 1'b0, hi);
		chk_near(hi, 0, 0);
		temp(1000);
		repeat (5 * PC) @(posedge clk);
		rchk(A_ACTUATE, 16'h0000);
		// proportional only, then limited error, then bias
		u_host.wr(A_KI, 16'h0000);
		temp(990);
		repeat (5 * PC) @(posedge clk);
		rchk(A_ACTUATE, 16'h000A);
		u_host.wr(A_ERR_LIMIT, 16'h0004);
		repeat (2 * PC) @(posedge clk);
		rchk(A_ACTUATE, 16'h0004);
		u_host.set_bias(1'b1, 16'h0064);
		repeat (2 * PC) @(posedge clk);
		rchk(A_ACTUATE, 16'h025C);
		heat_count(5 * PC, 1'b0, hi);
		chk_near(hi, 5 * PC * 604 / 6000, PC / 8);
		u_host.set_bias(1'b1, 16'h03E8);
		repeat (2 * PC) @(posedge clk);
		heat_count(PC, 1'b0, hi);
		chk_near(hi, PC, 0);
		u_host.set_bias(1'b1, 16'hFC18);
		repeat (2 * PC) @(posedge clk);
		heat_count(PC, 1'b0, hi);
		chk_near(hi, 0, 0);
		// manual full on: deviation, upper alarm cut, flag clear, lower alarm
		u_host.set_bias(1'b0, 16'h0000);
		u_host.wr(A_MANUAL, 16'h03E8);
		u_host.wr(A_CONTROL, 16'h0001);
		u_host.wr(A_STATUS, 16'h0003);
		temp(1600);
		repeat (PC) @(posedge clk);
		rchk(A_CAPTURED, 16'h0640);
		chk({15'h0000, ctrl_err}, 16'h0001);
		heat_count(PC, 1'b0, hi);
		chk_near(hi, PC, 0);
		temp(2100);
		repeat (PC) @(posedge clk);
		u_host.rd(A_STATUS, rv);
		chk({13'h0000, rv[2:0]}, 16'h0007);
		rchk(A_CAPTURED, 16'h0834);
		heat_count(PC, 1'b0, hi);
		chk_near(hi, 0, 0);
		temp(1000);
		u_host.wr(A_LO_ALARM, 16'h00C8);
		u_host.wr(A_STATUS, 16'h0003);
		u_host.rd(A_STATUS, rv);
		chk({13'h0000, rv[2:0]}, 16'h0000);
		temp(700);
		repeat (PC) @(posedge clk);
		u_host.rd(A_STATUS, rv);
		chk({13'h0000, rv[2:0]}, 16'h0002);
		heat_count(PC, 1'b0, hi);
		chk_near(hi, PC, 0);
		summarize();
	end
endmodule : zone_pid_pwm_temperature_loop_tb

// >>> zone_pkg.sv
package zone_pkg;
	// register bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	// parameter offsets; parameter number reported in errors is offset plus one
	localparam logic [4:0] A_SETPOINT = 5'h00;
	localparam logic [4:0] A_MANUAL = 5'h01;
	localparam logic [4:0] A_ERR_LIMIT = 5'h02;
	localparam logic [4:0] A_LIN_ZONE = 5'h03;
	localparam logic [4:0] A_EXT_COMP = 5'h04;
	localparam logic [4:0] A_BIAS = 5'h05;
	localparam logic [4:0] A_KP = 5'h06;
	localparam logic [4:0] A_KI = 5'h07;
	localparam logic [4:0] A_KD = 5'h08;
	localparam logic [4:0] A_PERIOD = 5'h09;
	localparam logic [4:0] A_UP_DEV = 5'h0A;
	localparam logic [4:0] A_LO_DEV = 5'h0B;
	localparam logic [4:0] A_UP_ALARM = 5'h0C;
	localparam logic [4:0] A_LO_ALARM = 5'h0D;
	localparam logic [4:0] A_CONFIG = 5'h0E;
	localparam logic [4:0] A_CONTROL = 5'h0F;
	localparam logic [4:0] A_STATUS = 5'h10;
	localparam logic [4:0] A_CAPTURED = 5'h11;
	localparam logic [4:0] A_MEASURED = 5'h12;
	localparam logic [4:0] A_ERRCODE = 5'h13;
	localparam logic [4:0] A_ACTUATE = 5'h14;
	// configuration, control and status bit positions
	localparam int CFG_TYPE_HI = 1;
	localparam int CFG_EXT_RTD = 3;
	localparam int CFG_HOST_COMP = 6;
	localparam int CFG_IN_USE = 7;
	localparam int CTL_OUT_EN = 0;
	localparam int CTL_AUTO = 1;
	localparam int ST_DEV = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_ALARM_OFF = 2;
	localparam int ST_ACTIVE = 3;
	// sensor types and their full scale in 0.1 degree
	localparam logic [1:0] TYPE_K = 2'b00;
	localparam logic [1:0] TYPE_J = 2'b01;
	localparam logic [1:0] TYPE_L = 2'b10;
	localparam logic [15:0] FULL_K = 16'h1770;
	localparam logic [15:0] FULL_JL = 16'h1194;
	// download limits
	localparam logic [15:0] LIM_MANUAL = 16'h03E8;
	localparam logic [15:0] LIM_TEMP = 16'h1964;
	localparam logic [15:0] LIM_GAIN = 16'h7D00;
	localparam logic [15:0] LIM_PER_LO = 16'h000A;
	localparam logic [15:0] LIM_PER_HI = 16'h1770;
	localparam logic [15:0] LIM_UP_ALARM_LO = 16'h00C8;
	localparam logic [15:0] LIM_CONFIG = 16'h03FF;
	localparam logic signed [15:0] LIM_BIAS = 16'sh03E8;
	localparam logic [3:0] CHANNEL_NUM = 4'h1;
	// reset values
	localparam logic [15:0] RST_PERIOD = 16'h0064;
	localparam logic [15:0] RST_ONE = 16'h0001;
	// scale factors of gains and units
	localparam int KP_DIV = 1000;
	localparam int KI_DIV = 10000;
	localparam int KD_MUL = 10;
	localparam int KD_DIV = 6;
	localparam int DUTY_DIV = 1000;
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_MS = 1;
	localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
	localparam int PERIOD_UNIT_MS = 10;
	localparam int QUANT_MS = 8;
	// one zone's downloaded parameter set
	typedef struct packed {
		logic [15:0] setpoint;
		logic [15:0] manual;
		logic [15:0] err_limit;
		logic [15:0] lin_zone;
		logic [15:0] ext_comp;
		logic [15:0] bias;
		logic [15:0] proportional_gain;
		logic [15:0] integral_gain;
		logic [15:0] derivative_gain;
		logic [15:0] pulse_period;
		logic [15:0] up_dev;
		logic [15:0] lo_dev;
		logic [15:0] up_alarm;
		logic [15:0] lo_alarm;
		logic [15:0] cfg_word;
	} zone_param_s;
endpackage : zone_pkg

// >>> zone_pulse_gen.sv
`timescale 1ns/10ps
module zone_pulse_gen import zone_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [15:0] i_period_ms,
	input wire logic [15:0] i_on_ms,
	output logic o_heat,
	output logic o_sample
);
	logic [31:0] div_r;
	logic [15:0] ms_r;
	logic [15:0] on_len_r;
	logic [2:0] res_r;
	logic full_r;
	logic heat_r;

	////////////////////////////////////////////////////////////////
	// millisecond time base and period boundary
	wire ms_tick = (div_r == 32'(MS_CYCLES - 1));
	wire last_ms = (ms_r >= i_period_ms - 16'h0001);
	assign o_sample = ms_tick & last_ms;
	// quantise to whole 8 ms units, carrying the leftover forward
	wire full_nxt = (i_on_ms >= i_period_ms);
	wire [16:0] total = {1'b0, i_on_ms} + {14'h0000, res_r};
	wire [15:0] on_len_nxt = full_nxt ? i_period_ms : {total[15:3], 3'h0};
	wire [2:0] res_nxt = full_nxt ? 3'h0 : total[2:0];

	// counters; a period change takes effect at the next boundary at latest
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_r <= 32'h0000_0000;
			ms_r <= 16'h0000;
		end else begin
			div_r <= ms_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
			ms_r <= ms_tick ? (last_ms ? 16'h0000 : ms_r + 16'h0001) : ms_r;
		end
	end

	// on-time is taken only at the boundary so a pulse is never cut short
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			on_len_r <= 16'h0000;
			res_r <= 3'h0;
			full_r <= 1'b0;
			heat_r <= 1'b0;
		end else begin
			if (o_sample) begin
				on_len_r <= on_len_nxt;
				res_r <= res_nxt;
				full_r <= full_nxt;
			end
			heat_r <= (ms_r < on_len_r);
		end
	end
	assign o_heat = heat_r;

	////////////////////////////////////////////////////////////////
	// checks
	a_on_whole_units: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		!full_r |-> (on_len_r[2:0] == 3'h0))
		else $error("pulse length not whole 8 ms units");
	a_residue_carry: assert property (@(posedge i_clk) disable iff (!i_rst_b)
		(o_sample && !full_nxt) |=> ({1'b0, on_len_r} + {14'h0000, res_r}
		== $past(total)))
		else $error("interpolation lost on-time");
endmodule : zone_pulse_gen
